/* inc/shc_map.svh */
// Function
// [RQ1] Function disable refused unless heater off; on and transition differ.
// [RQ2] Function disabled: on/off commands ignored, heater status hidden.
// [RQ3] Heater current accepted only 5 to 125 mA; supplied while heater on.
// [RQ4] Heater current write outside off state ignored and flagged as error.
// [RQ5] Delay accepted only 5 to 100 seconds; times warming and cooling.
// [RQ6] New delay value applies from the next transition only.
// [RQ7] Output setpoint changes blocked while warming or cooling.
// [RQ8] Persistent rate used when enabled and heater off, else normal rate.
// [RQ9] Normal rate writes rejected while persistent rate in use.
// [RQ10] Persistent rate never clamped to the maximum ramp rate limit.
// [RQ11] Persistent rate accepted only 0.0001 to 99.999 A/s.
// [RQ12] No heater current sourced in off state.
// [RQ13] On command: warming, indicator blinks; after delay on, steady.
// [RQ14] Off command: cooling, indicator blinks; after delay off, dark.
// [RQ15] On/off commands rejected while output ramping or in compliance.
// [RQ16] Setpoint stored at turn-off; mismatch at turn-on needs confirming.
// [RQ17] Yes starts warming despite mismatch; no or escape cancels, heater off.
// [RQ18] Confirmed mismatch turn-on drives magnet at compliance voltage limit.
// [RQ19] Delay counter loaded at transition start, decremented each second.
`ifndef SHC_MAP_SVH
`define SHC_MAP_SVH

// Register byte offsets
`define SHC_OFS_CTRL     8'h00
`define SHC_OFS_CURRENT  8'h04
`define SHC_OFS_DELAY    8'h08
`define SHC_OFS_PM_RATE  8'h0C
`define SHC_OFS_NM_RATE  8'h10
`define SHC_OFS_CMD      8'h14
`define SHC_OFS_STATUS   8'h18
`define SHC_OFS_IRQ_STAT 8'h1C
`define SHC_OFS_IRQ_MASK 8'h20
`define SHC_OFS_LAST_SP  8'h24

// Control fields
`define SHC_CTRL_EN      0
`define SHC_CTRL_PM_EN   1
// Command fields
`define SHC_CMD_ON       0
`define SHC_CMD_OFF      1
`define SHC_CMD_YES      2
`define SHC_CMD_NO       3
// Event fields in status and mask
`define SHC_EV_DIS_ON    0
`define SHC_EV_DIS_TRAN  1
`define SHC_EV_CUR_LOCK  2
`define SHC_EV_RANGE     3
`define SHC_EV_CMD_REJ   4
`define SHC_EV_CONFIRM   5
`define SHC_EV_DONE      6
`define SHC_EV_RATE_REJ  7
`define SHC_EV_W         8

// Limits: current in mA, delay in s, rate in 0.0001 A/s
`define SHC_CUR_MIN      7'h05
`define SHC_CUR_MAX      7'h7D
`define SHC_DLY_MIN      7'h05
`define SHC_DLY_MAX      7'h64
`define SHC_RATE_MIN     20'h0_0001
`define SHC_RATE_MAX     20'hF_4236

// Reset values
`define SHC_RST_CUR      7'h7D
`define SHC_RST_DLY      7'h0A
`define SHC_RST_PM_RATE  20'h0_C350
`define SHC_RST_NM_RATE  20'h0_03E8

`endif

/* inc/shc_pkg.sv */
package shc_pkg;
    // Heater sequence states
    typedef enum logic [1:0] {
        SHC_OFF,
        SHC_WARMING,
        SHC_ON,
        SHC_COOLING
    } shc_state_t;
endpackage

/* design/shc_ctrl.sv */
`timescale 1ns/1ps
`include "shc_map.svh"

module shc_ctrl
    import shc_pkg::*;
#(
    parameter int SP_W = 32
) (
    input  wire logic            CLK_I,
    input  wire logic            RST_I,
    input  wire logic            PSEL_I,
    input  wire logic            PENABLE_I,
    input  wire logic            PWRITE_I,
    input  wire logic [7:0]      PADDR_I,
    input  wire logic [31:0]     PWDATA_I,
    output logic      [31:0]     PRDATA_O,
    output logic                 PREADY_O,
    output logic                 PSLVERR_O,
    input  wire logic            TICK_1S_I,
    input  wire logic            RAMPING_I,
    input  wire logic            COMPLIANCE_I,
    input  wire logic [SP_W-1:0] SETPOINT_I,
    output logic      [6:0]      HEATER_MA_O,
    output logic                 LED_O,
    output logic                 SHOW_STATUS_O,
    output logic                 SETPT_LOCK_O,
    output logic                 USE_PM_RATE_O,
    output logic      [19:0]     RATE_O,
    output logic                 COMP_RAMP_O,
    output logic      [1:0]      STATE_O,
    output logic                 IRQ_O
);

    shc_state_t                 state_q, state_d;
    logic                       en_q, en_d;
    logic                       pm_en_q, pm_en_d;
    logic       [6:0]           cur_q, cur_d;
    logic       [6:0]           dly_q, dly_d;
    logic       [6:0]           cnt_q, cnt_d;
    logic       [19:0]          pm_rate_q, pm_rate_d;
    logic       [19:0]          nm_rate_q, nm_rate_d;
    logic       [SP_W-1:0]      last_sp_q, last_sp_d;
    logic                       pend_q, pend_d;
    logic                       comp_q, comp_d;
    logic                       blink_q, blink_d;
    logic       [`SHC_EV_W-1:0] stat_q, stat_d;
    logic       [`SHC_EV_W-1:0] mask_q, mask_d;
    logic       [`SHC_EV_W-1:0] ev, ev_cfg;
    logic       [31:0]          rdata_d;
    logic                       wr, rd, hit;
    logic                       cmd_on, cmd_off, cmd_yes, cmd_no;
    logic                       busy, use_pm;

    // Zero-wait slave: every access completes in its first access cycle
    assign PREADY_O  = 1'b1;
    assign wr        = PSEL_I & PENABLE_I & PWRITE_I;
    assign rd        = PSEL_I & PENABLE_I & ~PWRITE_I;
    assign PSLVERR_O = PSEL_I & PENABLE_I & ~hit;

    always_comb begin
        unique case (PADDR_I)
            `SHC_OFS_CTRL, `SHC_OFS_CURRENT, `SHC_OFS_DELAY,
            `SHC_OFS_PM_RATE, `SHC_OFS_NM_RATE, `SHC_OFS_CMD,
            `SHC_OFS_STATUS, `SHC_OFS_IRQ_STAT, `SHC_OFS_IRQ_MASK,
            `SHC_OFS_LAST_SP: hit = 1'b1;
            default:          hit = 1'b0;
        endcase
    end

    // Command strobes; a pulse, never stored
    assign cmd_on  = wr & (PADDR_I == `SHC_OFS_CMD) & PWDATA_I[`SHC_CMD_ON];
    assign cmd_off = wr & (PADDR_I == `SHC_OFS_CMD) & PWDATA_I[`SHC_CMD_OFF];
    assign cmd_yes = wr & (PADDR_I == `SHC_OFS_CMD) & PWDATA_I[`SHC_CMD_YES];
    assign cmd_no  = wr & (PADDR_I == `SHC_OFS_CMD) & PWDATA_I[`SHC_CMD_NO];

    // Switching the heater while the output moves risks a quench
    assign busy   = RAMPING_I | COMPLIANCE_I; // [RQ15]
    assign use_pm = pm_en_q & (state_q == SHC_OFF); // [RQ8]

    // Heater sequencer, delay counter and confirmation
    always_comb begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        pend_d    = pend_q;
        comp_d    = comp_q;
        last_sp_d = last_sp_q;
        blink_d   = blink_q ^ TICK_1S_I;
        ev        = '0;
        unique case (state_q)
            SHC_OFF: begin
                if (pend_q) begin
                    // Escape or no abandons the request, heater stays off
                    if (cmd_no | ~en_q) begin
                        pend_d = 1'b0; // [RQ17]
                    end else if (cmd_yes) begin
                        pend_d  = 1'b0;
                        state_d = SHC_WARMING; // [RQ17]
                        cnt_d   = dly_q; // [RQ19]
                        comp_d  = 1'b1; // [RQ18]
                    end
                end else if (cmd_on & en_q) begin // [RQ2]
                    if (busy) begin
                        ev[`SHC_EV_CMD_REJ] = 1'b1; // [RQ15]
                    end else if (SETPOINT_I != last_sp_q) begin
                        pend_d = 1'b1; // [RQ16]
                        ev[`SHC_EV_CONFIRM] = 1'b1;
                    end else begin
                        state_d = SHC_WARMING; // [RQ13]
                        cnt_d   = dly_q; // [RQ6] [RQ19]
                    end
                end
            end
            SHC_WARMING, SHC_COOLING: begin
                if (cnt_q == 7'h00) begin
                    state_d = (state_q == SHC_WARMING) ? SHC_ON : SHC_OFF;
                    ev[`SHC_EV_DONE] = 1'b1; // [RQ13] [RQ14]
                end else if (TICK_1S_I) begin
                    cnt_d = cnt_q - 7'h01; // [RQ19]
                end
            end
            SHC_ON: begin
                if (cmd_off & en_q) begin // [RQ2]
                    if (busy) begin
                        ev[`SHC_EV_CMD_REJ] = 1'b1; // [RQ15]
                    end else begin
                        state_d   = SHC_COOLING; // [RQ14]
                        cnt_d     = dly_q; // [RQ6] [RQ19]
                        last_sp_d = SETPOINT_I; // [RQ16]
                        comp_d    = 1'b0;
                    end
                end
            end
        endcase
        if ((cmd_on | cmd_off) & en_q & busy & state_q != SHC_OFF
            & state_q != SHC_ON) begin
            ev[`SHC_EV_CMD_REJ] = 1'b1;
        end
    end

    // Configuration registers with range and state guards
    always_comb begin
        en_d      = en_q;
        pm_en_d   = pm_en_q;
        cur_d     = cur_q;
        dly_d     = dly_q;
        pm_rate_d = pm_rate_q;
        nm_rate_d = nm_rate_q;
        mask_d    = mask_q;
        ev_cfg    = '0; // Own vector: one driver per event group
        if (wr) begin
            unique case (PADDR_I)
                `SHC_OFS_CTRL: begin
                    pm_en_d = PWDATA_I[`SHC_CTRL_PM_EN];
                    if (PWDATA_I[`SHC_CTRL_EN] | state_q == SHC_OFF) begin
                        en_d = PWDATA_I[`SHC_CTRL_EN];
                    end else if (state_q == SHC_ON) begin
                        ev_cfg[`SHC_EV_DIS_ON] = 1'b1; // [RQ1]
                    end else begin
                        ev_cfg[`SHC_EV_DIS_TRAN] = 1'b1; // [RQ1]
                    end
                end
                `SHC_OFS_CURRENT: begin
                    if (state_q != SHC_OFF) begin
                        ev_cfg[`SHC_EV_CUR_LOCK] = 1'b1; // [RQ4]
                    end else if (PWDATA_I[31:7] == '0
                        && PWDATA_I[6:0] >= `SHC_CUR_MIN
                        && PWDATA_I[6:0] <= `SHC_CUR_MAX) begin
                        cur_d = PWDATA_I[6:0]; // [RQ3]
                    end else begin
                        ev_cfg[`SHC_EV_RANGE] = 1'b1;
                    end
                end
                `SHC_OFS_DELAY: begin
                    // Allowed in any state; counter holds its own copy
                    if (PWDATA_I[31:7] == '0
                        && PWDATA_I[6:0] >= `SHC_DLY_MIN
                        && PWDATA_I[6:0] <= `SHC_DLY_MAX) begin
                        dly_d = PWDATA_I[6:0]; // [RQ5] [RQ6]
                    end else begin
                        ev_cfg[`SHC_EV_RANGE] = 1'b1;
                    end
                end
                `SHC_OFS_PM_RATE: begin
                    // No max-rate clamp: persistent rate bypasses the limit
                    if (PWDATA_I[31:20] == '0
                        && PWDATA_I[19:0] >= `SHC_RATE_MIN
                        && PWDATA_I[19:0] <= `SHC_RATE_MAX) begin
                        pm_rate_d = PWDATA_I[19:0]; // [RQ10] [RQ11]
                    end else begin
                        ev_cfg[`SHC_EV_RANGE] = 1'b1;
                    end
                end
                `SHC_OFS_NM_RATE: begin
                    if (use_pm) begin
                        ev_cfg[`SHC_EV_RATE_REJ] = 1'b1; // [RQ9]
                    end else if (PWDATA_I[31:20] == '0
                        && PWDATA_I[19:0] >= `SHC_RATE_MIN
                        && PWDATA_I[19:0] <= `SHC_RATE_MAX) begin
                        nm_rate_d = PWDATA_I[19:0]; // [RQ9]
                    end else begin
                        ev_cfg[`SHC_EV_RANGE] = 1'b1;
                    end
                end
                `SHC_OFS_IRQ_MASK: mask_d = PWDATA_I[`SHC_EV_W-1:0];
                default: ;
            endcase
        end
    end

    // Sticky events; a new event wins over a same-cycle clear
    always_comb begin
        stat_d = stat_q;
        if (wr && PADDR_I == `SHC_OFS_IRQ_STAT) begin
            stat_d = stat_q & ~PWDATA_I[`SHC_EV_W-1:0];
        end
        stat_d = stat_d | ev | ev_cfg;
    end

    // Read mux; combinational, so data is valid only in the access phase
    always_comb begin
        rdata_d = '0;
        if (rd) begin
            unique case (PADDR_I)
                `SHC_OFS_CTRL:     rdata_d = {30'h0, pm_en_q, en_q};
                `SHC_OFS_CURRENT:  rdata_d = {25'h0, cur_q};
                `SHC_OFS_DELAY:    rdata_d = {25'h0, dly_q};
                `SHC_OFS_PM_RATE:  rdata_d = {12'h0, pm_rate_q};
                `SHC_OFS_NM_RATE:  rdata_d = {12'h0, nm_rate_q};
                `SHC_OFS_STATUS:
                    rdata_d = {21'h0, cnt_q, comp_q, pend_q, state_q};
                `SHC_OFS_IRQ_STAT: rdata_d = {24'h0, stat_q};
                `SHC_OFS_IRQ_MASK: rdata_d = {24'h0, mask_q};
                `SHC_OFS_LAST_SP:  rdata_d = 32'(last_sp_q);
                default:           rdata_d = '0;
            endcase
        end
    end
    assign PRDATA_O = rdata_d;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            state_q   <= SHC_OFF;
            en_q      <= 1'b0;
            pm_en_q   <= 1'b0;
            cur_q     <= `SHC_RST_CUR;
            dly_q     <= `SHC_RST_DLY;
            cnt_q     <= 7'h00;
            pm_rate_q <= `SHC_RST_PM_RATE;
            nm_rate_q <= `SHC_RST_NM_RATE;
            last_sp_q <= '0;
            pend_q    <= 1'b0;
            comp_q    <= 1'b0;
            blink_q   <= 1'b0;
            stat_q    <= '0;
            mask_q    <= '0;
        end else begin
            state_q   <= state_d;
            en_q      <= en_d;
            pm_en_q   <= pm_en_d;
            cur_q     <= cur_d;
            dly_q     <= dly_d;
            cnt_q     <= cnt_d;
            pm_rate_q <= pm_rate_d;
            nm_rate_q <= nm_rate_d;
            last_sp_q <= last_sp_d;
            pend_q    <= pend_d;
            comp_q    <= comp_d;
            blink_q   <= blink_d;
            stat_q    <= stat_d;
            mask_q    <= mask_d;
        end
    end

    // Outputs; heater is fed while warming so the switch can go normal
    assign HEATER_MA_O = (state_q == SHC_WARMING || state_q == SHC_ON)
                         ? cur_q : 7'h00; // [RQ3] [RQ12]
    assign LED_O = (state_q == SHC_ON) |
                   (blink_q & (state_q == SHC_WARMING
                               || state_q == SHC_COOLING)); // [RQ13] [RQ14]
    assign SHOW_STATUS_O = en_q; // [RQ2]
    assign SETPT_LOCK_O  = (state_q == SHC_WARMING)
                         | (state_q == SHC_COOLING); // [RQ7]
    assign USE_PM_RATE_O = use_pm;
    assign RATE_O        = use_pm ? pm_rate_q : nm_rate_q; // [RQ8] [RQ10]
    assign COMP_RAMP_O   = comp_q & (state_q != SHC_OFF); // [RQ18]
    assign STATE_O       = state_q;
    assign IRQ_O         = |(stat_q & mask_q);

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    AST_DIS_GUARD: assert property ( // [RQ1]
        (wr && PADDR_I == `SHC_OFS_CTRL && !PWDATA_I[`SHC_CTRL_EN]
         && en_q && state_q != SHC_OFF) |=> en_q && stat_q[1:0] != 2'b00)
        else $error("heater function disabled while not off");
    AST_DIS_IGNORE: assert property ( // [RQ2]
        (!en_q && state_q == SHC_OFF && !pend_q) |=> state_q == SHC_OFF)
        else $error("command acted while function disabled");
    AST_CUR_RANGE: assert property ( // [RQ3]
        cur_q >= `SHC_CUR_MIN && cur_q <= `SHC_CUR_MAX)
        else $error("heater current out of range");
    AST_CUR_LOCK: assert property ( // [RQ4]
        (wr && PADDR_I == `SHC_OFS_CURRENT && state_q != SHC_OFF)
        |=> $stable(cur_q) && stat_q[`SHC_EV_CUR_LOCK])
        else $error("heater current changed outside off");
    AST_DLY_RANGE: assert property ( // [RQ5]
        dly_q >= `SHC_DLY_MIN && dly_q <= `SHC_DLY_MAX)
        else $error("delay out of range");
    AST_CNT_LOAD: assert property ( // [RQ6]
        (state_q == SHC_OFF && state_d == SHC_WARMING)
        |=> cnt_q == $past(dly_q))
        else $error("counter not loaded from delay");
    AST_CNT_DEC: assert property ( // [RQ19]
        (SETPT_LOCK_O && TICK_1S_I && cnt_q != 7'h00)
        |=> cnt_q == $past(cnt_q) - 7'h01)
        else $error("counter missed a tick");
    AST_LOCK: assert property ( // [RQ7]
        (state_q == SHC_ON && state_d == SHC_COOLING)
        |=> SETPT_LOCK_O [*1] ##0 LED_O == blink_q)
        else $error("cooling not locked or indicator wrong");
    AST_RATE_SEL: assert property ( // [RQ8]
        RATE_O == ((pm_en_q && state_q == SHC_OFF) ? pm_rate_q : nm_rate_q))
        else $error("wrong ramp rate selected");
    AST_HTR_OFF: assert property ( // [RQ12]
        state_q == SHC_OFF |-> HEATER_MA_O == 7'h00)
        else $error("heater fed while off");
    AST_BUSY_REJ: assert property ( // [RQ15]
        (state_q == SHC_OFF && !pend_q && cmd_on && busy)
        |=> state_q == SHC_OFF && !pend_q)
        else $error("heater-on accepted while busy");
    AST_CONFIRM: assert property ( // [RQ16]
        (state_q == SHC_OFF && !pend_q && en_q && cmd_on && !busy
         && SETPOINT_I != last_sp_q) |=> pend_q && state_q == SHC_OFF)
        else $error("mismatch did not ask for confirmation");

endmodule

/* dv/shc_plant.sv */
`timescale 1ns/1ps

// Far side: free running seconds tick and ramp logic status levels
module shc_plant #(
    parameter int TICK_GAP = 12
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [1:0] busy_mode_i,
    output logic            tick_o,
    output logic            ramping_o,
    output logic            compliance_o
);
    int gap_q;

    // One cycle pulse, far enough apart that no tick lands on a done cycle
    always_ff @(posedge clk_i) begin
        if (rst_i || gap_q == TICK_GAP - 1) begin
            gap_q <= 0;
        end else begin
            gap_q <= gap_q + 1;
        end
        tick_o <= !rst_i && gap_q == TICK_GAP - 1;
    end

    // Busy levels that must hold off heater commands
    assign ramping_o    = busy_mode_i == 2'h1;
    assign compliance_o = busy_mode_i == 2'h2;
endmodule

/* dv/shc_ctrl_tb.sv */
`timescale 1ns/1ps
`include "shc_map.svh"

module shc_ctrl_tb
    import shc_pkg::*;
;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, setpoint, sp, e;
    logic [1:0]  busy_mode, state;
    logic        tick, ramping, compliance, led, show, lock, use_pm;
    logic        comp, irq, er;
    logic [6:0]  heater_ma;
    logic [19:0] rate;
    logic [31:0] exp_q[$];
    logic        err_q[$];
    int          mismatches, cmp_count, seed, t0;
    int          tick_n = 0;

    shc_ctrl uut (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .TICK_1S_I(tick), .RAMPING_I(ramping),
        .COMPLIANCE_I(compliance), .SETPOINT_I(setpoint),
        .HEATER_MA_O(heater_ma), .LED_O(led), .SHOW_STATUS_O(show),
        .SETPT_LOCK_O(lock), .USE_PM_RATE_O(use_pm), .RATE_O(rate),
        .COMP_RAMP_O(comp), .STATE_O(state), .IRQ_O(irq));

    shc_plant plant (.clk_i(clk), .rst_i(rst), .busy_mode_i(busy_mode),
        .tick_o(tick), .ramping_o(ramping), .compliance_o(compliance));

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task end_of_test;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task cmp_rd(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: bus %h not %h", $time, got, exp);
        end
    endtask

    task cmp_port(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: port %h not %h", $time, got, exp);
        end
    endtask

    // One APB transfer; the expectation is queued for the monitor
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             input logic [31:0] x, input logic xe);
        int k;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        exp_q.push_back(x);
        err_q.push_back(xe);
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            mismatches++;
            end_of_test();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, x, 1'b0);
    endtask

    // Let the edge's updates land before looking at the ports
    task settle;
        @(posedge clk);
        #1;
    endtask

    // Bounded wait for a state, then check the ticks spent in transition
    task wait_st(input logic [1:0] s, input int t);
        int k;
        k = 0;
        while (state !== s && k < 1000) begin
            settle();
            k++;
        end
        if (k >= 1000) begin
            mismatches++;
            end_of_test();
        end
        cmp_port(tick_n - t0, t);
    endtask

    // Bus monitor takes the oldest note at each completed access
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1) begin
            e  = exp_q.pop_front();
            er = err_q.pop_front();
            cmp_rd(pslverr, er);
            if (!pwrite && !er) begin
                cmp_rd(prdata, e);
            end
        end
    end

    // Ticks seen in WARMING or COOLING (odd state codes)
    always @(posedge clk) begin
        if (tick === 1'b1 && state[0] === 1'b1) begin
            tick_n <= tick_n + 1;
        end
    end

    initial begin
        logic [7:0]  ta [3];
        logic [31:0] lo [3], hi [3], ok [3], rv [3];
        seed = 76579;
        mismatches = 0;
        cmp_count = 0;
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        setpoint = 32'h0;
        busy_mode = 2'h0;
        ta = '{`SHC_OFS_CURRENT, `SHC_OFS_DELAY, `SHC_OFS_PM_RATE};
        lo = '{32'h4, 32'h4, 32'h0};
        hi = '{32'h7E, 32'h65, 32'hF_4237};
        rv = '{32'h7D, 32'hA, 32'hC350};
        ok = '{32'h5 + $unsigned($random(seed)) % 121, 32'h5, 32'hF_4236};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        // Reset values, write-only command word, unmapped place
        rd(`SHC_OFS_CTRL, 32'h0);
        rd(`SHC_OFS_NM_RATE, 32'h3E8);
        rd(`SHC_OFS_CMD, 32'h0);
        apb(1'b0, 8'h30, 32'h0, 32'h0, 1'b1);
        // Commands while the function is off are dropped silently
        wr(`SHC_OFS_CMD, 32'h1);
        settle();
        cmp_port(state, SHC_OFF);
        cmp_port(show, 1'b0);
        rd(`SHC_OFS_IRQ_STAT, 32'h0);
        // Both range ends refused, old value kept, then a legal value
        for (int i = 0; i < 3; i++) begin
            wr(ta[i], lo[i]);
            wr(ta[i], hi[i]);
            rd(ta[i], rv[i]);
            rd(`SHC_OFS_IRQ_STAT, 32'h8);
            wr(`SHC_OFS_IRQ_STAT, 32'hFF);
            wr(ta[i], ok[i]);
            rd(ta[i], ok[i]);
        end
        wr(`SHC_OFS_CTRL, 32'h1);
        wr(`SHC_OFS_IRQ_MASK, 32'h10);
        settle();
        cmp_port(show, 1'b1);
        cmp_port({use_pm, rate}, 32'h3E8);
        // Ramping, then compliance: heater-on refused, interrupt raised
        for (int i = 1; i < 3; i++) begin
            busy_mode <= i[1:0];
            wr(`SHC_OFS_CMD, 32'h1);
            settle();
            cmp_port(state, SHC_OFF);
            cmp_port(irq, 1'b1);
            wr(`SHC_OFS_IRQ_STAT, 32'hFF);
            settle();
            cmp_port(irq, 1'b0);
        end
        busy_mode <= 2'h0;
        // Warm up with equal setpoint; edits during warming
        t0 = tick_n;
        wr(`SHC_OFS_CMD, 32'h1);
        settle();
        cmp_port({state, lock}, {SHC_WARMING, 1'b1});
        cmp_port(heater_ma, ok[0][6:0]);
        wr(`SHC_OFS_DELAY, 32'h6);
        wr(`SHC_OFS_CURRENT, 32'h9);
        wr(`SHC_OFS_CTRL, 32'h0);
        wr(`SHC_OFS_CMD, 32'h2);
        rd(`SHC_OFS_IRQ_STAT, 32'h6);
        rd(`SHC_OFS_CURRENT, ok[0]);
        wr(`SHC_OFS_IRQ_STAT, 32'hFF);
        wait_st(SHC_ON, 5);
        cmp_port({led, lock}, 2'h2);
        wr(`SHC_OFS_CTRL, 32'h0);
        rd(`SHC_OFS_IRQ_STAT, 32'h41);
        wr(`SHC_OFS_IRQ_STAT, 32'hFF);
        // Cool down with the new delay; setpoint stored at turn-off
        sp = $random(seed);
        setpoint <= sp;
        t0 = tick_n;
        wr(`SHC_OFS_CMD, 32'h2);
        settle();
        cmp_port({state, lock}, {SHC_COOLING, 1'b1});
        cmp_port(heater_ma, 7'h00);
        wait_st(SHC_OFF, 6);
        cmp_port({led, heater_ma}, 8'h0);
        rd(`SHC_OFS_LAST_SP, sp);
        wr(`SHC_OFS_IRQ_STAT, 32'hFF);
        // Mismatch: no cancels, stray yes ignored, then yes confirms
        setpoint <= sp + 32'h1;
        wr(`SHC_OFS_CMD, 32'h1);
        rd(`SHC_OFS_IRQ_STAT, 32'h20);
        wr(`SHC_OFS_CMD, 32'h8);
        wr(`SHC_OFS_CMD, 32'h4);
        settle();
        cmp_port(state, SHC_OFF);
        t0 = tick_n;
        wr(`SHC_OFS_CMD, 32'h1);
        wr(`SHC_OFS_CMD, 32'h4);
        settle();
        cmp_port({state, comp}, {SHC_WARMING, 1'b1});
        wait_st(SHC_ON, 6);
        t0 = tick_n;
        wr(`SHC_OFS_CMD, 32'h2);
        wait_st(SHC_OFF, 6);
        cmp_port(comp, 1'b0);
        // Persistent rate in OFF: unclamped, blocks normal rate edits
        wr(`SHC_OFS_IRQ_STAT, 32'hFF);
        wr(`SHC_OFS_CTRL, 32'h3);
        settle();
        cmp_port({use_pm, rate}, 32'h1F_4236);
        wr(`SHC_OFS_NM_RATE, 32'h5);
        rd(`SHC_OFS_NM_RATE, 32'h3E8);
        rd(`SHC_OFS_IRQ_STAT, 32'h80);
        wr(`SHC_OFS_CTRL, 32'h1);
        wr(`SHC_OFS_NM_RATE, 32'h7);
        settle();
        cmp_port({use_pm, rate}, 32'h7);
        // Disabling the function is allowed once the heater is off
        wr(`SHC_OFS_CTRL, 32'h0);
        rd(`SHC_OFS_CTRL, 32'h0);
        settle();
        cmp_port(show, 1'b0);
        end_of_test();
    end
endmodule
